/* File: light_prox_consts.svh */
`ifndef LIGHT_PROX_CONSTS_SVH
`define LIGHT_PROX_CONSTS_SVH

// Register byte offsets.
`define ADDR_PART_ID      8'h00
`define ADDR_CONFIG       8'h01
`define ADDR_INT          8'h02
`define ADDR_NEAR_LO      8'h03
`define ADDR_NEAR_HI      8'h04
`define ADDR_LIGHT_TH1    8'h05
`define ADDR_LIGHT_TH2    8'h06
`define ADDR_LIGHT_TH3    8'h07
`define ADDR_NEAR_DATA    8'h08
`define ADDR_LIGHT_LSB    8'h09
`define ADDR_LIGHT_MSB    8'h0A

// Field positions of the sensing configuration register.
`define CFG_SPECTRUM_BIT  0
`define CFG_RANGE_BIT     1
`define CFG_LIGHT_EN_BIT  2
`define CFG_LED_DRIVE_BIT 3
`define CFG_SLEEP_LSB     4
`define CFG_SLEEP_MSB     6
`define CFG_NEAR_EN_BIT   7

// Field positions of the interrupt status and control register.
`define INT_COMBINE_BIT   0
`define INT_LPERS_LSB     1
`define INT_LPERS_MSB     2
`define INT_LFLAG_BIT     3
`define INT_UNUSED_BIT    4
`define INT_NPERS_LSB     5
`define INT_NPERS_MSB     6
`define INT_NFLAG_BIT     7

// Reset values.
`define RST_CONFIG        8'h00
`define RST_INT_CTRL      8'h00
`define RST_NEAR_LO       8'h00
`define RST_NEAR_HI       8'hFF
`define RST_LIGHT_TH1     8'h00
`define RST_LIGHT_TH2     8'hF0
`define RST_LIGHT_TH3     8'hFF
`define RST_RESULT        8'h00

// Full scale of the two light ranges in lux and LED pulse currents in mA.
`define FSR_LOW_LUX       125
`define FSR_HIGH_LUX      2000
`define LED_LOW_MA        110
`define LED_HIGH_MA       220

// Timing: clock rate in MHz, conversion time and sleep times in microseconds.
`define CLK_MHZ           200
`define NEAR_CONV_US      540
`define SLEEP_000_US      800000
`define SLEEP_001_US      400000
`define SLEEP_010_US      200000
`define SLEEP_011_US      100000
`define SLEEP_100_US      75000
`define SLEEP_101_US      50000
`define SLEEP_110_US      12500
`define SLEEP_111_US      0

// Persistence lengths in consecutive samples for codes 0 to 3.
`define PERSIST_N0        5'd1
`define PERSIST_N1        5'd4
`define PERSIST_N2        5'd8
`define PERSIST_N3        5'd16

`endif

/* File: light_prox_pkg.sv */
`include "light_prox_consts.svh"

package light_prox_pkg;

  // One register byte.
  typedef logic [7:0] reg_byte_t;

  // Proximity conversion sequencer states.
  typedef enum logic [1:0] {SEQ_OFF, SEQ_CONV, SEQ_SLEEP} near_seq_t;

  // Number of consecutive samples that a persistence code asks for.
  function automatic logic [4:0] persist_len(input logic [1:0] code);
    logic [4:0] n;
    n = `PERSIST_N0;
    unique case (code)
      2'd0: n = `PERSIST_N0;
      2'd1: n = `PERSIST_N1;
      2'd2: n = `PERSIST_N2;
      2'd3: n = `PERSIST_N3;
    endcase
    return n;
  endfunction

endpackage

/* File: persist_filter.sv */
module persist_filter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_i,
  input  wire logic       hit_i,
  input  wire logic [1:0] code_i,
  output logic            fire_o
);
  import light_prox_pkg::*;

  logic [4:0] cnt_ff;   // Consecutive hits seen so far, saturated at the need.
  logic [4:0] nxt_cnt;  // Next hit count.
  logic [4:0] need;     // Length asked for by the persistence code.
  logic [4:0] inc;      // Count including the present sample.

  assign need = persist_len(code_i);
  assign inc  = cnt_ff + 5'h01;

  // A miss restarts the run; a hit extends it up to the needed length.
  assign nxt_cnt = !hit_i ? 5'h00 : ((inc >= need) ? need : inc);

  // Fires on every sample that completes or continues a long enough run.
  assign fire_o = sample_i & hit_i & (inc >= need);

  // The count only moves on a finished conversion.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 5'h00;
    end else if (sample_i) begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

/* File: reg_link_bridge.sv */
module reg_link_bridge (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     link_clk_i,
  input  wire logic                     link_req_i,
  input  wire logic                     link_we_i,
  input  wire light_prox_pkg::reg_byte_t link_addr_i,
  input  wire light_prox_pkg::reg_byte_t link_wdata_i,
  output logic                          link_busy_o,
  output light_prox_pkg::reg_byte_t     link_rdata_o,
  output logic                          link_done_o,
  output logic                          core_req_o,
  output logic                          core_we_o,
  output light_prox_pkg::reg_byte_t     core_addr_o,
  output light_prox_pkg::reg_byte_t     core_wdata_o,
  input  wire light_prox_pkg::reg_byte_t core_rdata_i
);
  import light_prox_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain.

  logic      lrst_s1_ff;   // Reset synchroniser, first stage.
  logic      lrst_ff;      // Reset as seen on the link clock.
  logic      req_tgl_ff;   // Flips once per accepted request.
  logic      we_hold_ff;   // Held write flag.
  reg_byte_t addr_hold_ff; // Held address.
  reg_byte_t data_hold_ff; // Held write data.
  logic      ack_s1_ff;    // Answer toggle, first stage.
  logic      ack_s2_ff;    // Answer toggle, second stage.
  logic      ack_s3_ff;    // Answer toggle, edge reference.
  logic      ack_tgl_ff;   // Flips once per served request (core clock).
  reg_byte_t rdata_ff;     // Read answer, stable until the next request (core clock).
  logic      ack_seen;     // The core has answered.
  logic      req_take;     // A request is accepted this link cycle.

  assign ack_seen = ack_s2_ff ^ ack_s3_ff;
  assign req_take = link_req_i & !link_busy_o;

  // Reset is carried over into the link domain by two flip-flops.
  always_ff @(posedge link_clk_i) begin
    lrst_s1_ff <= rst_i;
    lrst_ff    <= lrst_s1_ff;
  end

  // A request is held still until answered, so the core may read the held
  // words directly; requests made while busy are dropped.
  always_ff @(posedge link_clk_i) begin
    if (lrst_ff) begin
      req_tgl_ff   <= 1'b0;
      we_hold_ff   <= 1'b0;
      addr_hold_ff <= 8'h00;
      data_hold_ff <= 8'h00;
    end else if (req_take) begin
      req_tgl_ff   <= !req_tgl_ff;
      we_hold_ff   <= link_we_i;
      addr_hold_ff <= link_addr_i;
      data_hold_ff <= link_wdata_i;
    end
  end

  // The answer toggle is synchronised; its edge ends the request.
  always_ff @(posedge link_clk_i) begin
    if (lrst_ff) begin
      ack_s1_ff    <= 1'b0;
      ack_s2_ff    <= 1'b0;
      ack_s3_ff    <= 1'b0;
      link_busy_o  <= 1'b0;
      link_done_o  <= 1'b0;
      link_rdata_o <= 8'h00;
    end else begin
      ack_s1_ff   <= ack_tgl_ff;
      ack_s2_ff   <= ack_s1_ff;
      ack_s3_ff   <= ack_s2_ff;
      link_done_o <= ack_seen;
      if (ack_seen) begin
        link_busy_o  <= 1'b0;
        link_rdata_o <= rdata_ff;
      end else if (req_take) begin
        link_busy_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain.

  logic      req_s1_ff;  // Request toggle, first stage.
  logic      req_s2_ff;  // Request toggle, second stage.
  logic      req_s3_ff;  // Request toggle, edge reference.

  assign core_req_o   = req_s2_ff ^ req_s3_ff;
  assign core_we_o    = we_hold_ff;
  assign core_addr_o  = addr_hold_ff;
  assign core_wdata_o = data_hold_ff;

  // The request is served in the cycle its edge is seen, then answered.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s1_ff  <= 1'b0;
      req_s2_ff  <= 1'b0;
      req_s3_ff  <= 1'b0;
      ack_tgl_ff <= 1'b0;
      rdata_ff   <= 8'h00;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      if (core_req_o) begin
        ack_tgl_ff <= !ack_tgl_ff;
        rdata_ff   <= core_rdata_i;
      end
    end
  end
endmodule

/* File: light_prox_ctrl.sv */
// Function
// (R1) Spectrum select picks visible or infrared result
// (R2) Range bit selects 125 or 2000 lux
// (R3) Light enable turns both light channels on
// (R4) Drive bit selects 110 or 220 mA
// (R5) Sleep code sets idle between proximity conversions
// (R6) Conversion lasts 0.54 ms, default sleep 800
// (R7) Proximity enable starts sensing, clear at reset
// (R8) Host leaves identification register alone
// (R9) Combine bit selects OR or AND
// (R10) Interrupt pin open drain, low when active
// (R11) Writing zero clears flags, releases pin
// (R12) Light persistence needs 1/4/8/16 outside samples
// (R13) Light flag set outside threshold window
// (R14) Light flag sticky, cleared by zero write
// (R15) Proximity flag set after N above-threshold conversions
// (R16) Proximity flag self-clears after N below-threshold
// (R17) Host clears proximity flag writing all zeros
// (R18) Proximity flag means near, from 8-bit compare
// (R19) Light thresholds from byte plus nibble
// (R20) Results refresh per conversion, zero at reset
// (R21) Unused interrupt bit reads back zero
`include "light_prox_consts.svh"

module light_prox_ctrl #(
  parameter logic [7:0]  PART_ID  = 8'h5A,  // Arbitrary identification value.
  parameter int unsigned CONV_CYC = `NEAR_CONV_US * `CLK_MHZ,
  parameter logic [31:0] SLEEP_CYC [8] = '{
    32'(`SLEEP_000_US * `CLK_MHZ), 32'(`SLEEP_001_US * `CLK_MHZ),
    32'(`SLEEP_010_US * `CLK_MHZ), 32'(`SLEEP_011_US * `CLK_MHZ),
    32'(`SLEEP_100_US * `CLK_MHZ), 32'(`SLEEP_101_US * `CLK_MHZ),
    32'(`SLEEP_110_US * `CLK_MHZ), 32'(`SLEEP_111_US * `CLK_MHZ)}
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      link_clk_i,
  input  wire logic                      link_req_i,
  input  wire logic                      link_we_i,
  input  wire light_prox_pkg::reg_byte_t link_addr_i,
  input  wire light_prox_pkg::reg_byte_t link_wdata_i,
  output logic                           link_busy_o,
  output light_prox_pkg::reg_byte_t      link_rdata_o,
  output logic                           link_done_o,
  input  wire logic                      light_done_i,
  input  wire logic [11:0]               light_vis_i,
  input  wire logic [11:0]               light_ir_i,
  input  wire light_prox_pkg::reg_byte_t near_adc_i,
  output logic                           light_sense_en_o,
  output logic                           light_range_sel_o,
  output logic                           light_spectrum_sel_o,
  output logic                           led_drive_strength_o,
  output logic                           near_convert_o,
  input  wire logic                      int_in_i,
  output logic                           int_out_o,
  output logic                           int_oe_o
);
  import light_prox_pkg::*;

  // The sequencer timer is 32 bits wide and needs at least one cycle.
  if (CONV_CYC < 1) begin : g_bad_conv
    $error("CONV_CYC must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  logic      core_req;    // One-cycle access pulse from the bridge.
  logic      core_we;     // Access is a write.
  reg_byte_t core_addr;   // Register offset of the access.
  reg_byte_t core_wdata;  // Write data.
  reg_byte_t rd_data;     // Selected read value.

  // Accesses arrive on the link clock and are served here one at a time.
  reg_link_bridge u_bridge (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .link_clk_i   (link_clk_i),
    .link_req_i   (link_req_i),
    .link_we_i    (link_we_i),
    .link_addr_i  (link_addr_i),
    .link_wdata_i (link_wdata_i),
    .link_busy_o  (link_busy_o),
    .link_rdata_o (link_rdata_o),
    .link_done_o  (link_done_o),
    .core_req_o   (core_req),
    .core_we_o    (core_we),
    .core_addr_o  (core_addr),
    .core_wdata_o (core_wdata),
    .core_rdata_i (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  reg_byte_t   cfg_ff;          // Sensing configuration.
  logic        combine_ff;      // Interrupt combine: 0 OR, 1 AND.
  logic [1:0]  light_pers_ff;   // Light persistence code.
  logic [1:0]  near_pers_ff;    // Proximity persistence code.
  logic        light_flag_ff;   // Light event flag.
  logic        near_flag_ff;    // Proximity flag, high means near.
  reg_byte_t   near_lo_ff;      // Lower proximity threshold.
  reg_byte_t   near_hi_ff;      // Upper proximity threshold.
  reg_byte_t   th1_ff;          // Lower light threshold, low byte.
  reg_byte_t   th2_ff;          // Upper low nibble and lower high nibble.
  reg_byte_t   th3_ff;          // Upper light threshold, high byte.
  reg_byte_t   near_data_ff;    // Last proximity result.
  logic [11:0] light_data_ff;   // Last light result.

  logic wr_cfg;      // Write strobe, configuration.
  logic wr_int;      // Write strobe, interrupt register.
  logic wr_near_lo;  // Write strobe, lower proximity threshold.
  logic wr_near_hi;  // Write strobe, upper proximity threshold.
  logic wr_th1;      // Write strobe, light threshold byte 1.
  logic wr_th2;      // Write strobe, light threshold byte 2.
  logic wr_th3;      // Write strobe, light threshold byte 3.

  assign wr_cfg     = core_req & core_we & (core_addr == `ADDR_CONFIG);
  assign wr_int     = core_req & core_we & (core_addr == `ADDR_INT);
  assign wr_near_lo = core_req & core_we & (core_addr == `ADDR_NEAR_LO);
  assign wr_near_hi = core_req & core_we & (core_addr == `ADDR_NEAR_HI);
  assign wr_th1     = core_req & core_we & (core_addr == `ADDR_LIGHT_TH1);
  assign wr_th2     = core_req & core_we & (core_addr == `ADDR_LIGHT_TH2);
  assign wr_th3     = core_req & core_we & (core_addr == `ADDR_LIGHT_TH3);

  reg_byte_t int_view;  // Interrupt register as read back.

  // The unused bit is never stored, so it always reads zero.
  assign int_view = {near_flag_ff, near_pers_ff, 1'b0, light_flag_ff,
                     light_pers_ff, combine_ff};  // [R21]

  // Offsets past the map read as zero; the identification byte is served
  // even though software is not meant to touch it.
  assign rd_data =
    (core_addr == `ADDR_PART_ID)   ? PART_ID :  // [R8]
    (core_addr == `ADDR_CONFIG)    ? cfg_ff :
    (core_addr == `ADDR_INT)       ? int_view :
    (core_addr == `ADDR_NEAR_LO)   ? near_lo_ff :
    (core_addr == `ADDR_NEAR_HI)   ? near_hi_ff :
    (core_addr == `ADDR_LIGHT_TH1) ? th1_ff :
    (core_addr == `ADDR_LIGHT_TH2) ? th2_ff :
    (core_addr == `ADDR_LIGHT_TH3) ? th3_ff :
    (core_addr == `ADDR_NEAR_DATA) ? near_data_ff :
    (core_addr == `ADDR_LIGHT_LSB) ? light_data_ff[7:0] :
    (core_addr == `ADDR_LIGHT_MSB) ? {4'h0, light_data_ff[11:8]} :
    8'h00;

  // Plain read-write registers; proximity sensing starts disabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff     <= `RST_CONFIG;  // [R7]
      near_lo_ff <= `RST_NEAR_LO;
      near_hi_ff <= `RST_NEAR_HI;
      th1_ff     <= `RST_LIGHT_TH1;  // [R19]
      th2_ff     <= `RST_LIGHT_TH2;  // [R19]
      th3_ff     <= `RST_LIGHT_TH3;  // [R19]
    end else begin
      if (wr_cfg)     cfg_ff     <= core_wdata;
      if (wr_near_lo) near_lo_ff <= core_wdata;
      if (wr_near_hi) near_hi_ff <= core_wdata;
      if (wr_th1)     th1_ff     <= core_wdata;
      if (wr_th2)     th2_ff     <= core_wdata;
      if (wr_th3)     th3_ff     <= core_wdata;
    end
  end

  // Configuration fields drive the analogue front end through one register stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      light_sense_en_o     <= 1'b0;
      light_range_sel_o    <= 1'b0;
      light_spectrum_sel_o <= 1'b0;
      led_drive_strength_o <= 1'b0;
    end else begin
      light_sense_en_o     <= cfg_ff[`CFG_LIGHT_EN_BIT];   // [R3]
      light_range_sel_o    <= cfg_ff[`CFG_RANGE_BIT];      // [R2]
      light_spectrum_sel_o <= cfg_ff[`CFG_SPECTRUM_BIT];   // [R1]
      led_drive_strength_o <= cfg_ff[`CFG_LED_DRIVE_BIT];  // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Proximity conversion sequencer.

  near_seq_t   seq_ff;     // Present sequencer state.
  near_seq_t   nxt_seq;    // Next sequencer state.
  logic [31:0] timer_ff;   // Cycles left in the present phase.
  logic [31:0] nxt_timer;  // Next timer value.
  logic        near_en;    // Proximity sensing enabled.
  logic [31:0] sleep_len;  // Sleep length for the present code.
  logic        near_end;   // A proximity conversion finishes this cycle.

  assign near_en   = cfg_ff[`CFG_NEAR_EN_BIT];  // [R7]
  assign sleep_len = SLEEP_CYC[cfg_ff[`CFG_SLEEP_MSB:`CFG_SLEEP_LSB]];  // [R5]
  assign near_end  = near_en & (seq_ff == SEQ_CONV) & (timer_ff == 32'h0);

  // Convert, then sleep for the chosen time; a zero sleep converts back to
  // back. A sleep code written mid-sleep only acts on the next sleep.
  always_comb begin
    nxt_seq   = seq_ff;
    nxt_timer = timer_ff;
    unique case (seq_ff)
      SEQ_OFF: begin
        if (near_en) begin
          nxt_seq   = SEQ_CONV;
          nxt_timer = 32'(CONV_CYC - 1);  // [R6]
        end
      end
      SEQ_CONV: begin
        if (!near_en) begin
          nxt_seq = SEQ_OFF;
        end else if (timer_ff != 32'h0) begin
          nxt_timer = timer_ff - 32'h1;
        end else if (sleep_len == 32'h0) begin
          nxt_timer = 32'(CONV_CYC - 1);  // [R5]
        end else begin
          nxt_seq   = SEQ_SLEEP;
          nxt_timer = sleep_len - 32'h1;  // [R6]
        end
      end
      SEQ_SLEEP: begin
        if (!near_en) begin
          nxt_seq = SEQ_OFF;
        end else if (timer_ff != 32'h0) begin
          nxt_timer = timer_ff - 32'h1;
        end else begin
          nxt_seq   = SEQ_CONV;
          nxt_timer = 32'(CONV_CYC - 1);
        end
      end
    endcase
  end

  // The convert output is the LED and converter window.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_ff         <= SEQ_OFF;
      timer_ff       <= 32'h0;
      near_convert_o <= 1'b0;
    end else begin
      seq_ff         <= nxt_seq;
      timer_ff       <= nxt_timer;
      near_convert_o <= (nxt_seq == SEQ_CONV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results.

  logic        light_sample;  // A light conversion is taken this cycle.
  logic [11:0] light_value;   // The chosen spectrum's result.

  assign light_sample = light_done_i & cfg_ff[`CFG_LIGHT_EN_BIT];  // [R3]
  assign light_value  = cfg_ff[`CFG_SPECTRUM_BIT] ? light_ir_i : light_vis_i;  // [R1]

  // Each finished conversion replaces the stored result.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      near_data_ff  <= `RST_RESULT;  // [R20]
      light_data_ff <= 12'h000;      // [R20]
    end else begin
      if (near_end)     near_data_ff  <= near_adc_i;   // [R20]
      if (light_sample) light_data_ff <= light_value;  // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt pin.

  logic [11:0] light_lo;     // Lower light threshold.
  logic [11:0] light_hi;     // Upper light threshold.
  logic        light_out;    // Light result outside the window.
  logic        light_fire;   // Light persistence satisfied.
  logic        near_fire;    // Enough conversions at or above upper.
  logic        near_drop;    // Enough conversions at or below lower.
  logic        int_active;   // Selected flag combination is true.

  assign light_lo  = {th2_ff[3:0], th1_ff};  // [R19]
  assign light_hi  = {th3_ff, th2_ff[7:4]};  // [R19]
  // Touching a threshold counts as outside, as crossing does.
  assign light_out = (light_value <= light_lo) | (light_value >= light_hi);  // [R13]

  persist_filter u_light_pers (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (light_sample),
    .hit_i    (light_out),
    .code_i   (light_pers_ff),  // [R12]
    .fire_o   (light_fire)
  );

  persist_filter u_near_set (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (near_end),
    .hit_i    (near_adc_i >= near_hi_ff),  // [R18]
    .code_i   (near_pers_ff),              // [R15]
    .fire_o   (near_fire)
  );

  persist_filter u_near_clr (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (near_end),
    .hit_i    (near_adc_i <= near_lo_ff),  // [R18]
    .code_i   (near_pers_ff),              // [R16]
    .fire_o   (near_drop)
  );

  localparam reg_byte_t INT_RST = `RST_INT_CTRL;  // Reset image of the interrupt register.

  // Flags set by an event win over a clear in the same cycle, so no event
  // is lost to a racing write; writing a one leaves a flag untouched.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      combine_ff    <= INT_RST[`INT_COMBINE_BIT];
      light_pers_ff <= INT_RST[`INT_LPERS_MSB:`INT_LPERS_LSB];
      near_pers_ff  <= INT_RST[`INT_NPERS_MSB:`INT_NPERS_LSB];
      light_flag_ff <= 1'b0;
      near_flag_ff  <= 1'b0;
    end else begin
      if (wr_int) begin
        combine_ff    <= core_wdata[`INT_COMBINE_BIT];
        light_pers_ff <= core_wdata[`INT_LPERS_MSB:`INT_LPERS_LSB];
        near_pers_ff  <= core_wdata[`INT_NPERS_MSB:`INT_NPERS_LSB];
      end
      if (light_fire) begin
        light_flag_ff <= 1'b1;  // [R13] [R14]
      end else if (wr_int && !core_wdata[`INT_LFLAG_BIT]) begin
        light_flag_ff <= 1'b0;  // [R11] [R14]
      end
      if (near_fire) begin
        near_flag_ff <= 1'b1;  // [R15] [R18]
      end else if (near_drop || (wr_int && !core_wdata[`INT_NFLAG_BIT])) begin
        near_flag_ff <= 1'b0;  // [R11] [R16] [R17]
      end
    end
  end

  assign int_active = combine_ff ? (light_flag_ff & near_flag_ff)
                                 : (light_flag_ff | near_flag_ff);  // [R9]

  // The pin is only ever pulled low; releasing it leaves it to the pull-up.
  assign int_out_o = 1'b0;  // [R10]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_oe_o <= 1'b0;
    end else begin
      int_oe_o <= int_active;  // [R10] [R11]
    end
  end
endmodule

/* File: light_prox_checker_assertions.sv */
module light_prox_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_req_i,
  input wire logic link_busy_o,
  input wire logic light_done_i,
  input wire logic light_sense_en_o,
  input wire logic light_range_sel_o,
  input wire logic light_spectrum_sel_o,
  input wire logic led_drive_strength_o,
  input wire logic near_convert_o,
  input wire logic int_out_o,
  input wire logic int_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Settings move only while an access is pending.
  sequence s_acc; link_req_i || link_busy_o; endsequence
  sequence s_conv; near_convert_o [*4]; endsequence
  property p_en; $changed(light_sense_en_o) |-> s_acc; endproperty
  a_en: assert property (p_en) else $error("enable moved idle");
  property p_rng; light_range_sel_o != $past(light_range_sel_o) |-> s_acc; endproperty
  a_rng: assert property (p_rng) else $error("range moved idle");
  property p_sd; $changed({light_spectrum_sel_o, led_drive_strength_o}) |-> s_acc; endproperty
  a_sd: assert property (p_sd) else $error("select moved idle");
  property p_conv; $rose(near_convert_o) |-> s_conv; endproperty
  a_conv: assert property (p_conv) else $error("window too short");
  property p_rst; disable iff (1'b0) rst_i |=> !int_oe_o && !near_convert_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_od; int_out_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  // The pin only asserts after a sample or a write.
  property p_rise; $rose(int_oe_o) |-> link_req_i || link_busy_o || $past(light_done_i, 2)
    || $past(light_done_i, 3) || $past(near_convert_o, 2); endproperty
  a_rise: assert property (p_rise) else $error("pin rose uncaused");
  property p_fall; $fell(int_oe_o) |-> link_req_i || link_busy_o
    || $past(near_convert_o, 2) || $past(near_convert_o, 3); endproperty
  a_fall: assert property (p_fall) else $error("pin fell uncaused");
endmodule
bind light_prox_ctrl light_prox_checker light_prox_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .link_req_i(link_req_i), .link_busy_o(link_busy_o), .light_done_i(light_done_i),
  .light_sense_en_o(light_sense_en_o), .light_range_sel_o(light_range_sel_o),
  .light_spectrum_sel_o(light_spectrum_sel_o), .led_drive_strength_o(led_drive_strength_o),
  .near_convert_o(near_convert_o), .int_out_o(int_out_o), .int_oe_o(int_oe_o));

/* File: host_link_model.sv */
module host_link_model (
  input  wire logic                      link_clk_i,
  input  wire logic                      link_done_i,
  input  wire light_prox_pkg::reg_byte_t link_rdata_i,
  output logic                           link_req_o,
  output logic                           link_we_o,
  output light_prox_pkg::reg_byte_t      link_addr_o,
  output light_prox_pkg::reg_byte_t      link_wdata_o
);
  import light_prox_pkg::*;
  initial link_req_o = 1'b0;
  // One-cycle request; offset 0x00 is never used, bit 4 of offset 0x02 always written 0.
  task automatic access(input logic w, input reg_byte_t a, d, output reg_byte_t q, output bit ok);
    ok = 1'b0;
    @(negedge link_clk_i);
    link_req_o = 1'b1;
    link_we_o = w;
    link_addr_o = a;
    link_wdata_o = d;
    @(negedge link_clk_i);
    link_req_o = 1'b0;
    link_addr_o = ~a;
    link_wdata_o = ~d;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(negedge link_clk_i);
      ok = (link_done_i === 1'b1);
    end
    q = link_rdata_i;
  endtask
endmodule

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import light_prox_pkg::*;
  logic        clk_i = 1'b0, lclk = 1'b0, rst_i = 1'b1, dn = 1'b0;
  logic        req, we, busy, done, en, rng, spec, drv, conv, iout, ioe;
  logic [11:0] vis = 12'h000, ir = 12'h000;
  reg_byte_t   addr, wdata, rdata, q, adc = 8'h00;
  int          mismatches = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  initial begin #1.3; forever #62.5 lclk = ~lclk; end
  light_prox_ctrl #(.CONV_CYC(20), .SLEEP_CYC('{40, 35, 30, 25, 20, 15, 10, 0}))
    light_prox_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(lclk), .link_req_i(req),
    .link_we_i(we), .link_addr_i(addr), .link_wdata_i(wdata), .link_busy_o(busy),
    .link_rdata_o(rdata), .link_done_o(done), .light_done_i(dn), .light_vis_i(vis),
    .light_ir_i(ir), .near_adc_i(adc), .light_sense_en_o(en), .light_range_sel_o(rng),
    .light_spectrum_sel_o(spec), .led_drive_strength_o(drv), .near_convert_o(conv),
    .int_in_i(!ioe), .int_out_o(iout), .int_oe_o(ioe));
  host_link_model host_link_model_inst (.link_clk_i(lclk), .link_done_i(done),
    .link_rdata_i(rdata), .link_req_o(req), .link_we_o(we), .link_addr_o(addr),
    .link_wdata_o(wdata));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input reg_byte_t got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input reg_byte_t a, d);
    bit ok;
    host_link_model_inst.access(w, a, d, q, ok);
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t no done", $time);
      tally_and_finish();
    end
  endtask
  task automatic rd(input reg_byte_t a, e);
    acc(1'b0, a, 8'h00);
    cmp(q, e);
  endtask
  // One light result, then time for flag and pin to settle.
  task automatic lite(input logic [11:0] v, i);
    @(negedge clk_i);
    vis = v;
    ir = i;
    dn = 1'b1;
    @(negedge clk_i);
    dn = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  initial begin
    repeat (100) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge lclk);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h06, 8'hF0);
    rd(8'h07, 8'hFF);
    rd(8'h09, 8'h00);
    rd(8'h0B, 8'h00);
    acc(1'b1, 8'h01, 8'h0F);
    cmp({4'h0, drv, en, rng, spec}, 8'h0F);
    acc(1'b1, 8'h05, 8'h10);
    lite(12'h123, 12'h005);
    rd(8'h09, 8'h05);
    rd(8'h02, 8'h08);
    lite(12'h123, 12'h123);
    cmp({7'h00, ioe}, 8'h01);
    acc(1'b1, 8'h02, 8'h02);
    cmp({7'h00, ioe}, 8'h00);
    for (int k = 1; k <= 4; k++) begin
      lite(12'h123, 12'hFFF);
      cmp({7'h00, ioe}, {7'h00, 1'(k == 4)});
    end
    acc(1'b1, 8'h02, 8'h01);
    lite(12'h123, 12'h005);
    cmp({7'h00, ioe}, 8'h00);
    acc(1'b1, 8'h04, 8'h80);
    adc = 8'h90;
    acc(1'b1, 8'h01, 8'hFF);
    repeat (60) @(negedge clk_i);
    cmp({7'h00, ioe}, 8'h01);
    rd(8'h02, 8'h89);
    adc = 8'h00;
    repeat (60) @(negedge clk_i);
    rd(8'h02, 8'h09);
    acc(1'b1, 8'h02, 8'h00);
    rd(8'h02, 8'h00);
    tally_and_finish();
  end
endmodule
